// ==== rtl/fbp_burst_ctrl.v ====
// Function
// - standard program or erase turns pump on, off at completion
// - pump stays on only if next burst queued before completion flag
// - pump stays on only within same 32-byte burst block
// - first byte of burst series takes standard program time
// - later burst bytes take shorter burst time when conditions hold
// - new row start cycles high voltage and uses standard time
// - nothing queued at completion: pump off, high voltage removed
// - commands refused until divider written once; first write sets flag
// - flash clock is bus clock, optional divide by 8, over divisor+1
`timescale 1ns/10ps
`include "fbp_map.vh"
module fbp_burst_ctrl
(
	// clock and reset
	input  wire        core_clk,
	input  wire        reset_n,
	// avalon-mm slave
	input  wire [2:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// array side
	output reg         pumpOn_q,
	output reg         progStrobe_q,
	output reg  [15:0] arrayAddr_q,
	output reg  [7:0]  arrayData_q,
	// interrupt
	output reg         irq_q
);
	// states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_RUN  = 4'b0010;
	localparam [3:0] ST_GAP  = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;

	//==================================================
	// registers
	reg [3:0]  state_q;
	reg        divLoaded_q;
	reg        preDiv8_q;
	reg [5:0]  divisor_q;
	reg [15:0] addrReg_q;
	reg [7:0]  dataReg_q;
	reg        queued_q;
	reg [15:0] qAddr_q;
	reg [7:0]  qData_q;
	reg [7:0]  qCmd_q;
	reg [7:0]  curCmd_q;
	reg [7:0]  pulseCnt_q;
	reg        done_q;
	reg        refused_q;
	reg [1:0]  irqStat_q;
	reg [1:0]  irqEn_q;
	wire       tick;

	// flash clock tick enable
	// flash clock divider
	fbp_clk_div uDiv
	(
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (divLoaded_q),
		.preDiv8  (preDiv8_q),
		.divisor  (divisor_q),
		.tick_q   (tick)
	);

	//==================================================
	// bus decode
	// writes land on the acknowledge edge, reads fetch one edge earlier
	wire wrAcc  = avs_write && !avs_waitrequest;
	wire rdAcc  = avs_read && avs_waitrequest;
	wire wrDiv  = wrAcc && (avs_address == `FBP_ADDR_DIV);
	wire wrAddr = wrAcc && (avs_address == `FBP_ADDR_ADDR);
	wire wrCmd  = wrAcc && (avs_address == `FBP_ADDR_CMD);
	wire wrClr  = wrAcc && (avs_address == `FBP_ADDR_IRQ_CLR);
	wire wrEn   = wrAcc && (avs_address == `FBP_ADDR_IRQ_EN);
	wire [7:0] cmdIn = avs_writedata[7:0];
	wire cmdKnown = (cmdIn == `FBP_CMD_PROG) || (cmdIn == `FBP_CMD_BURST) ||
		(cmdIn == `FBP_CMD_ERASE);
	wire cmdOk = wrCmd && divLoaded_q && cmdKnown;
	wire cmdRefuse = wrCmd && !(divLoaded_q && cmdKnown &&
		((state_q == ST_IDLE) || (state_q == ST_DONE) ||
		(!queued_q && (curCmd_q == `FBP_CMD_BURST) && (cmdIn == `FBP_CMD_BURST))));
	wire startNew = cmdOk && ((state_q == ST_IDLE) || (state_q == ST_DONE));
	wire queueNew = cmdOk && !startNew && !queued_q &&
		(curCmd_q == `FBP_CMD_BURST) && (cmdIn == `FBP_CMD_BURST);

	// continuation test on the queued byte
	// same burst block
	wire sameBlock = (qAddr_q[15:`FBP_BLOCK_LSB] == arrayAddr_q[15:`FBP_BLOCK_LSB]);
	wire sequential = (qAddr_q == arrayAddr_q + 16'h0001);
	wire keepPump = queued_q && (qCmd_q == `FBP_CMD_BURST) && sameBlock && sequential;
	// finish one cycle after the last strobe, so the pump still covers it
	wire finishing = (state_q == ST_RUN) && progStrobe_q && (pulseCnt_q == 8'h00);
	// a burst queued in the finishing cycle is still served
	wire lastDone  = finishing && !queued_q && !queueNew;

	//==================================================
	// bus answer: one wait cycle, then acknowledge
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end
		else
		begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			// read data stands when waitrequest drops
			if (rdAcc)
			begin
				if (avs_address == `FBP_ADDR_DIV)
					avs_readdata <= {24'h000000, divLoaded_q, preDiv8_q, divisor_q};
				else if (avs_address == `FBP_ADDR_ADDR)
					avs_readdata <= {8'h00, dataReg_q, addrReg_q};
				else if (avs_address == `FBP_ADDR_CMD)
					avs_readdata <= {24'h000000, curCmd_q};
				else if (avs_address == `FBP_ADDR_STAT)
					avs_readdata <= {28'h0000000, refused_q, (state_q != ST_IDLE) &&
						(state_q != ST_DONE), pumpOn_q, done_q};
				else if (avs_address == `FBP_ADDR_IRQ_STAT)
					avs_readdata <= {30'h00000000, irqStat_q};
				else if (avs_address == `FBP_ADDR_IRQ_EN)
					avs_readdata <= {30'h00000000, irqEn_q};
				else
					avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// divider register, written once
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			divLoaded_q <= 1'b0;
			preDiv8_q   <= 1'b0;
			divisor_q   <= 6'h00;
		end
		// first write sets flag
		// later writes leave the divider as it is
		else if (wrDiv && !divLoaded_q)
		begin
			divLoaded_q <= 1'b1;
			preDiv8_q   <= avs_writedata[`FBP_DIV_PRE8];
			divisor_q   <= avs_writedata[`FBP_DIV_MSB:0];
		end
	end

	// address and data staging
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addrReg_q <= 16'h0000;
			dataReg_q <= 8'h00;
		end
		else if (wrAddr)
		begin
			addrReg_q <= avs_writedata[15:0];
			dataReg_q <= avs_writedata[23:16];
		end
	end

	//==================================================
	// sequencer
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q      <= ST_IDLE;
			pumpOn_q     <= 1'b0;
			progStrobe_q <= 1'b0;
			arrayAddr_q  <= 16'h0000;
			arrayData_q  <= 8'h00;
			queued_q     <= 1'b0;
			qAddr_q      <= 16'h0000;
			qData_q      <= 8'h00;
			qCmd_q       <= 8'h00;
			curCmd_q     <= 8'h00;
			pulseCnt_q   <= 8'h00;
		end
		else
		begin
			progStrobe_q <= 1'b0;
			// take one burst byte into the queue
			if (queueNew)
			begin
				queued_q <= 1'b1;
				qAddr_q  <= addrReg_q;
				qData_q  <= dataReg_q;
				qCmd_q   <= cmdIn;
			end
			case (state_q)
				ST_IDLE, ST_DONE:
				begin
					if (startNew)
					begin
						pumpOn_q    <= 1'b1;
						curCmd_q    <= cmdIn;
						arrayAddr_q <= addrReg_q;
						arrayData_q <= dataReg_q;
						pulseCnt_q  <= (cmdIn == `FBP_CMD_ERASE) ? `FBP_ERASE_PULSES :
							`FBP_STD_PULSES;
						state_q     <= ST_RUN;
					end
				end
				ST_RUN:
				begin
					// no strobe once the count is spent
					if (tick && (pulseCnt_q != 8'h00))
					begin
						progStrobe_q <= 1'b1;
						pulseCnt_q   <= pulseCnt_q - 8'h01;
					end
					if (finishing)
					begin
						if (keepPump)
						begin
							queued_q    <= 1'b0;
							curCmd_q    <= qCmd_q;
							arrayAddr_q <= qAddr_q;
							arrayData_q <= qData_q;
							pulseCnt_q  <= `FBP_BURST_PULSES;
						end
						// a byte queued in this very cycle also takes the gap
						else if (queued_q || queueNew)
						begin
							pumpOn_q <= 1'b0;
							state_q  <= ST_GAP;
						end
						else
						begin
							pumpOn_q <= 1'b0;
							state_q  <= ST_DONE;
						end
					end
				end
				ST_GAP:
				begin
					// pump back on, queued byte at standard time
					pumpOn_q    <= 1'b1;
					queued_q    <= 1'b0;
					curCmd_q    <= qCmd_q;
					arrayAddr_q <= qAddr_q;
					arrayData_q <= qData_q;
					pulseCnt_q  <= `FBP_STD_PULSES;
					state_q     <= ST_RUN;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// completion and refusal flags, set wins over clear
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			done_q    <= 1'b0;
			refused_q <= 1'b0;
			irqStat_q <= 2'b00;
			irqEn_q   <= 2'b00;
			irq_q     <= 1'b0;
		end
		else
		begin
			// flag set when nothing further runs
			if (lastDone)
				done_q <= 1'b1;
			else if (startNew)
				done_q <= 1'b0;
			if (cmdRefuse)
				refused_q <= 1'b1;
			else if (cmdOk)
				refused_q <= 1'b0;
			// done and refusal events raise sticky interrupt status
			irqStat_q[`FBP_IRQ_DONE] <= lastDone ||
				(irqStat_q[`FBP_IRQ_DONE] && !(wrClr && avs_writedata[`FBP_IRQ_DONE]));
			irqStat_q[`FBP_IRQ_REF] <= cmdRefuse ||
				(irqStat_q[`FBP_IRQ_REF] && !(wrClr && avs_writedata[`FBP_IRQ_REF]));
			if (wrEn)
				irqEn_q <= avs_writedata[1:0];
			irq_q <= |(irqStat_q & irqEn_q);
		end
	end
endmodule // fbp_burst_ctrl

// ==== rtl/fbp_map.vh ====
`ifndef FBP_MAP_VH
`define FBP_MAP_VH
// register word addresses (word index on the avalon bus)
`define FBP_ADDR_DIV      3'h0
`define FBP_ADDR_ADDR     3'h1
`define FBP_ADDR_CMD      3'h2
`define FBP_ADDR_STAT     3'h3
`define FBP_ADDR_IRQ_STAT 3'h4
`define FBP_ADDR_IRQ_CLR  3'h5
`define FBP_ADDR_IRQ_EN   3'h6
// divider register fields
`define FBP_DIV_LOADED    7
`define FBP_DIV_PRE8      6
`define FBP_DIV_MSB       5
// command codes
`define FBP_CMD_PROG      8'h20
`define FBP_CMD_BURST     8'h25
`define FBP_CMD_ERASE     8'h40
// status bits
`define FBP_ST_DONE       0
`define FBP_ST_PUMP       1
`define FBP_ST_BUSY       2
`define FBP_ST_REFUSED    3
// irq bits: done, refused
`define FBP_IRQ_DONE      0
`define FBP_IRQ_REF       1
// timing in flash clock pulses, prescaler end count in bus clocks
`define FBP_STD_PULSES    8'h09
`define FBP_BURST_PULSES  8'h04
`define FBP_ERASE_PULSES  8'hFF
`define FBP_PRE8_COUNT    3'h7
// burst block: 32 bytes, low five address bits
`define FBP_BLOCK_LSB     5
`endif

// ==== rtl/fbp_clk_div.v ====
`timescale 1ns/10ps
module fbp_clk_div
(
	// clock and reset
	input  wire       core_clk,
	input  wire       reset_n,
	// control
	input  wire       run,
	input  wire       preDiv8,
	input  wire [5:0] divisor,
	// flash clock enable
	output reg        tick_q
);
	reg [2:0] preCnt_q;
	reg [5:0] divCnt_q;
	wire      preTick = !preDiv8 || (preCnt_q == `FBP_PRE8_COUNT);

	// prescale then divide by divisor plus one
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			preCnt_q <= 3'h0;
			divCnt_q <= 6'h00;
			tick_q   <= 1'b0;
		end
		else if (!run)
		begin
			preCnt_q <= 3'h0;
			divCnt_q <= 6'h00;
			tick_q   <= 1'b0;
		end
		else
		begin
			preCnt_q <= preCnt_q + 3'h1;
			tick_q   <= 1'b0;
			if (preTick)
			begin
				if (divCnt_q == divisor)
				begin
					divCnt_q <= 6'h00;
					tick_q   <= 1'b1;
				end
				else
					divCnt_q <= divCnt_q + 6'h01;
			end
		end
	end
endmodule // fbp_clk_div

// ==== verification/fbp_burst_ctrl_assertions.sv ====
`timescale 1ns/10ps
module fbp_chk
(
	// bus side
	input wire        core_clk,
	input wire        reset_n,
	input wire [2:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire        avs_waitrequest,
	// array side
	input wire        pumpOn_q,
	input wire        progStrobe_q,
	input wire [15:0] arrayAddr_q,
	input wire        irq_q
);
	reg        divSeen_q;
	reg        enSeen_q;
	reg [8:0]  runCnt_q;
	reg [15:0] last_q;
	wire       wrDone = avs_write && !avs_waitrequest;
	// ====
	// helper state: config seen, strobes per pump run
	always @(posedge core_clk or negedge reset_n)
		if (!reset_n)
		begin
			divSeen_q <= 1'b0;
			enSeen_q <= 1'b0;
			runCnt_q <= 9'h000;
			last_q <= 16'h0000;
		end
		else
		begin
			divSeen_q <= divSeen_q | (wrDone && avs_address == 3'h0);
			enSeen_q <= enSeen_q | (wrDone && avs_address == 3'h6 && |avs_writedata[1:0]);
			runCnt_q <= pumpOn_q ? runCnt_q + {8'h00, progStrobe_q} : 9'h000;
			last_q <= progStrobe_q ? arrayAddr_q : last_q;
		end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	// ====
	// checks
	ack_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late ack");
	ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("long ack");
	idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
		else $error("idle ack");
	div_first_a: assert property (!divSeen_q |-> !pumpOn_q)
		else $error("pump before divider");
	strobe_pump_a: assert property (progStrobe_q |-> pumpOn_q)
		else $error("strobe without pump");
	pump_len_a: assert property ($fell(pumpOn_q) |-> runCnt_q == 9'h009 ||
		runCnt_q == 9'h0FF || (runCnt_q > 9'h009 && runCnt_q[1:0] == 2'h1))
		else $error("bad run length");
	seq_block_a: assert property (progStrobe_q && runCnt_q != 9'h000 &&
		arrayAddr_q != last_q |-> arrayAddr_q == last_q + 16'h0001 &&
		arrayAddr_q[15:5] == last_q[15:5])
		else $error("pump kept across block");
	irq_enable_a: assert property (!enSeen_q |-> !irq_q)
		else $error("irq while disabled");
	cover property ($fell(pumpOn_q) && runCnt_q == 9'h00D);
	cover property ($fell(pumpOn_q) && runCnt_q == 9'h0FF);
	cover property ($rose(irq_q));
endmodule // fbp_chk

bind fbp_burst_ctrl fbp_chk i_fbp_chk
(
	.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .pumpOn_q(pumpOn_q),
	.progStrobe_q(progStrobe_q), .arrayAddr_q(arrayAddr_q), .irq_q(irq_q)
);

// ==== verification/fbp_host_model.sv ====
`timescale 1ns/10ps
module fbp_host_model
(
	// clock
	input wire         core_clk,
	// avalon-mm master
	output reg  [2:0]  avs_address,
	output reg         avs_read,
	output reg         avs_write,
	output reg  [31:0] avs_writedata,
	input  wire [31:0] avs_readdata,
	input  wire        avs_waitrequest
);
	// ====
	// idle bus at time zero
	initial
	begin
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	// one access, held until waitrequest low
	task busCycle(input logic wr, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		begin
			@(posedge core_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_read <= !wr;
			avs_write <= wr;
			do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			avs_address <= ~a; // released lines toggle
			avs_writedata <= ~d;
		end
	endtask
endmodule // fbp_host_model

// ==== verification/fbp_burst_ctrl_tb.sv ====
`timescale 1ns/10ps
module fbp_burst_ctrl_tb;
	reg          core_clk;
	reg          reset_n;
	wire [2:0]   adr;
	wire         rdS, wrS, wait_n, pump, strobe, irq;
	wire [31:0]  wdat, rdat;
	wire [15:0]  aAddr;
	wire [7:0]   aData;
	logic [31:0] rd;
	logic [23:0] lastByte;
	int          n_fail = 0;
	int          n_tests = 0;
	int          runLen = 0;
	int          gap = 0;
	int          runs[$];
	int          k;
	fbp_burst_ctrl i_fbp_burst_ctrl (.core_clk(core_clk), .reset_n(reset_n),
		.avs_address(adr), .avs_read(rdS), .avs_write(wrS), .avs_writedata(wdat),
		.avs_readdata(rdat), .avs_waitrequest(wait_n), .pumpOn_q(pump),
		.progStrobe_q(strobe), .arrayAddr_q(aAddr), .arrayData_q(aData), .irq_q(irq));
	fbp_host_model i_fbp_host_model (.core_clk(core_clk), .avs_address(adr),
		.avs_read(rdS), .avs_write(wrS), .avs_writedata(wdat), .avs_readdata(rdat),
		.avs_waitrequest(wait_n));
	// ====
	// clock, watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		give_verdict;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_tests++;
			if (seen !== exp)
			begin
				n_fail++;
				$display("unexpected at %0t: value %h, wanted %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input logic [2:0] a, input logic [31:0] d);
		i_fbp_host_model.busCycle(1'b1, a, d, rd);
	endtask
	// masked register read and compare
	task rdChk(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
		begin
			i_fbp_host_model.busCycle(1'b0, a, 32'h0, rd);
			check(rd & m, e);
		end
	endtask
	task waitDone;
		begin
			wait (pump === 1'b1);
			do i_fbp_host_model.busCycle(1'b0, 3'h3, 32'h0, rd); while (rd[0] !== 1'b1);
		end
	endtask
	task give_verdict;
		begin
			if (n_fail == 0 && n_tests > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// strobe spacing and pump run lengths
	always @(negedge core_clk)
	begin
		gap++;
		if (strobe === 1'b1)
		begin
			if (runLen != 0 && {aData, aAddr} === lastByte) check(gap, 8);
			runLen++;
			gap = 0;
			lastByte = {aData, aAddr};
		end
		if (pump === 1'b0 && runLen != 0)
		begin
			runs.push_back(runLen);
			runLen = 0;
		end
	end
	// ====
	// test sequence
	initial
	begin
		reset_n = 1'b0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		rdChk(3'h0, 32'hFF, 32'h00);
		wr(3'h1, 32'h005A0010);
		wr(3'h2, 32'h20);
		rdChk(3'h3, 32'h0F, 32'h08);
		check(pump, 1'b0);
		wr(3'h6, 32'h03);
		rdChk(3'h6, 32'h03, 32'h03);
		check(irq, 1'b1);
		wr(3'h5, 32'h03);
		repeat (2) @(negedge core_clk);
		check(irq, 1'b0);
		wr(3'h0, 32'h07);
		wr(3'h0, 32'h7F);
		rdChk(3'h0, 32'hFF, 32'h87);
		rdChk(3'h7, 32'hFFFFFFFF, 32'h0);
		wr(3'h2, 32'h20);
		wr(3'h2, 32'h40);
		rdChk(3'h4, 32'h02, 32'h02);
		waitDone;
		check(runs.pop_front(), 9);
		check(lastByte, 24'h5A0010);
		check(irq, 1'b1);
		wr(3'h6, 32'h00);
		wr(3'h2, 32'h40);
		waitDone;
		check(runs.pop_front(), 255);
		check(irq, 1'b0);
		wr(3'h1, 32'h001E);
		wr(3'h2, 32'h25);
		for (k = 1; k < 4; k++)
		begin
			wait (lastByte[15:0] === 16'h001D + k[15:0]);
			wr(3'h1, {8'h00, k[7:0], 16'h001E + k[15:0] + {15'h0, k == 3}});
			wr(3'h2, 32'h25);
		end
		waitDone;
		check(runs.pop_front(), 13);
		check(runs.pop_front(), 9);
		check(runs.pop_front(), 9);
		check(lastByte, 24'h030022);
		// reset after the burst series completes, then the divide-by-eight prescaler
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		rdChk(3'h0, 32'hFF, 32'h00);
		wr(3'h0, 32'h40);
		rdChk(3'h0, 32'hFF, 32'hC0);
		wr(3'h1, 32'h00A50041);
		wr(3'h2, 32'h20);
		waitDone;
		check(runs.pop_front(), 9);
		check(lastByte, 24'hA50041);
		give_verdict;
	end
endmodule // fbp_burst_ctrl_tb
